// *** ubte_top.sv ***
`timescale 1ns/100ps
module ubte_top #(
  parameter int BUF_DEPTH = ubte_pkg::BUF_BYTES
) (
  input wire logic clk_sys,                   // system clock
  input wire logic rst,                       // sync reset, high
  input wire ubte_pkg::ubte_axi_req_t axi_req, // axi4-lite master side
  output ubte_pkg::ubte_axi_rsp_t axi_rsp,    // axi4-lite slave side
  input wire logic start_sw_pin,              // start switch, falling edge
  input wire logic rx_pin,                    // serial data in
  output logic tx_pin,                        // serial data out
  output logic [3:0] irq_req                  // cpu requests, levels
);
  import ubte_pkg::*;
  localparam int IW = $clog2(BUF_DEPTH);

  logic [2:0] sw_sync_q, sw_sync_d, rx_sync_q, rx_sync_d;
  logic sw_lvl_q, sw_lvl_d, rx_lvl_q, rx_lvl_d, sw_fall;
  logic [5:0] ctrl_q, ctrl_d;
  logic [7:0] baud_q, baud_d;
  logic [IW-1:0] tx_src_q, tx_src_d, rx_dst_q, rx_dst_d;
  logic [8:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  logic [1:0] eng_q, eng_d;
  logic start_q, start_d, txe_q, txe_d, rxf_q, rxf_d;
  logic txd_q, txd_d, ferr_q, ferr_d, ovr_q, ovr_d;
  logic [7:0] tx_buf_q [BUF_DEPTH];
  logic [7:0] tx_buf_d [BUF_DEPTH];
  logic [7:0] rx_buf_q [BUF_DEPTH];
  logic [7:0] rx_buf_d [BUF_DEPTH];
  logic [7:0] hold_q, hold_d, rx_hold_q, rx_hold_d;
  logic hold_full_q, hold_full_d;
  ubte_ser_st_t tx_st_q, tx_st_d, rx_st_q, rx_st_d;
  logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
  logic [2:0] tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d;
  logic [13:0] tx_tmr_q, tx_tmr_d, rx_tmr_q, rx_tmr_d, bit_cyc;
  logic tx_pin_q, tx_pin_d, tx_load, tx_end, rx_ok, rx_ferr;
  ubte_axi_rsp_t rsp_q, rsp_d;
  logic [AW-1:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [3:0] irq_q, irq_d;
  logic tx_go, rx_go;

  assign axi_rsp = rsp_q;
  assign tx_pin = tx_pin_q;
  assign irq_req = irq_q;

  // byte-lane merge for narrow registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // address decode shared by read and write paths
  function automatic logic is_mapped(input logic [AW-1:0] a);
    logic win;
    win = (a[11:10] == WIN_TXBUF) || (a[11:10] == WIN_RXBUF);
    return win || (a[11:5] == 7'h00);
  endfunction : is_mapped

  // three-stage sync; a level counts once stages two and three agree
  always_comb begin
    sw_sync_d = {sw_sync_q[1:0], start_sw_pin};
    rx_sync_d = {rx_sync_q[1:0], rx_pin};
    sw_lvl_d = (sw_sync_q[1] == sw_sync_q[2]) ? sw_sync_q[2] : sw_lvl_q;
    rx_lvl_d = (rx_sync_q[1] == rx_sync_q[2]) ? rx_sync_q[2] : rx_lvl_q;
    sw_fall = sw_lvl_q & ~sw_lvl_d;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sw_sync_q <= 3'h7;
      rx_sync_q <= 3'h7;
      sw_lvl_q <= 1'b1;
      rx_lvl_q <= 1'b1;
    end else begin
      sw_sync_q <= sw_sync_d;
      rx_sync_q <= rx_sync_d;
      sw_lvl_q <= sw_lvl_d;
      rx_lvl_q <= rx_lvl_d;
    end
  end

  // transmitter: start bit, 8 data lsb first, one stop
  always_comb begin
    bit_cyc = 14'({1'b0, baud_q} + 9'h001) << BAUD_SHIFT;
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_bit_d = tx_bit_q;
    tx_tmr_d = tx_tmr_q + 14'h0001;
    tx_load = 1'b0;
    tx_end = 1'b0;
    unique case (tx_st_q)
      ST_IDLE: begin
        tx_tmr_d = '0;
        if (hold_full_q) begin
          tx_load = 1'b1;
          tx_st_d = ST_START;
        end
      end
      ST_START: begin
        if (tx_tmr_q == bit_cyc - 14'h0001) begin
          tx_tmr_d = '0;
          tx_bit_d = '0;
          tx_st_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (tx_tmr_q == bit_cyc - 14'h0001) begin
          tx_tmr_d = '0;
          tx_sh_d = {1'b0, tx_sh_q[7:1]};
          tx_bit_d = tx_bit_q + 3'h1;
          if (tx_bit_q == 3'h7) tx_st_d = ST_STOP;
        end
      end
      ST_STOP: begin
        if (tx_tmr_q == bit_cyc - 14'h0001) begin
          tx_tmr_d = '0;
          // back to back when the engine already refilled the hold
          if (hold_full_q) begin
            tx_load = 1'b1;
            tx_st_d = ST_START;
          end else begin
            tx_end = 1'b1;
            tx_st_d = ST_IDLE;
          end
        end
      end
    endcase
    if (tx_load) tx_sh_d = hold_q;
    // switching tx off aborts the frame and idles the line
    if (!ctrl_q[C_TX_ON]) begin
      tx_st_d = ST_IDLE;
      tx_load = 1'b0;
      tx_end = 1'b0;
    end
    tx_pin_d = (tx_st_d == ST_START) ? 1'b0 : (tx_st_d == ST_DATA) ? tx_sh_d[0] : 1'b1;
  end

  // receiver: start qualified at half a bit, then mid-bit samples
  always_comb begin
    rx_st_d = rx_st_q;
    rx_sh_d = rx_sh_q;
    rx_bit_d = rx_bit_q;
    rx_tmr_d = rx_tmr_q + 14'h0001;
    rx_ok = 1'b0;
    rx_ferr = 1'b0;
    unique case (rx_st_q)
      ST_IDLE: begin
        rx_tmr_d = '0;
        if (!rx_lvl_q) rx_st_d = ST_START;
      end
      ST_START: begin
        if (rx_tmr_q == (bit_cyc >> 1) - 14'h0001) begin
          rx_tmr_d = '0;
          rx_bit_d = '0;
          rx_st_d = rx_lvl_q ? ST_IDLE : ST_DATA; // glitch rejected
        end
      end
      ST_DATA: begin
        if (rx_tmr_q == bit_cyc - 14'h0001) begin
          rx_tmr_d = '0;
          rx_sh_d = {rx_lvl_q, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == 3'h7) rx_st_d = ST_STOP;
        end
      end
      ST_STOP: begin
        if (rx_tmr_q == bit_cyc - 14'h0001) begin
          rx_ok = rx_lvl_q;
          rx_ferr = ~rx_lvl_q;
          rx_st_d = ST_IDLE;
        end
      end
    endcase
    if (!ctrl_q[C_RX_ON]) begin
      rx_st_d = ST_IDLE;
      rx_ok = 1'b0;
      rx_ferr = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_st_q <= ST_IDLE;
      rx_st_q <= ST_IDLE;
      tx_sh_q <= '0;
      rx_sh_q <= '0;
      tx_bit_q <= '0;
      rx_bit_q <= '0;
      tx_tmr_q <= '0;
      rx_tmr_q <= '0;
      tx_pin_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      rx_st_q <= rx_st_d;
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      tx_bit_q <= tx_bit_d;
      rx_bit_q <= rx_bit_d;
      tx_tmr_q <= tx_tmr_d;
      rx_tmr_q <= rx_tmr_d;
      tx_pin_q <= tx_pin_d;
    end
  end

  // engine starts: only the two data requests trigger a move
  assign tx_go = txe_q & ctrl_q[C_TXE_ON] & eng_q[0] & (tx_cnt_q != '0) & ~hold_full_q;
  assign rx_go = rxf_q & ctrl_q[C_RXF_ON] & eng_q[1] & (rx_cnt_q != '0);

  // bus slave, registers, engine and flags; hardware sets win over clears
  always_comb begin
    logic [31:0] wv;
    logic [AW-1:0] ra;
    wv = '0;
    ra = axi_req.araddr;
    rsp_d = rsp_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    ctrl_d = ctrl_q;
    baud_d = baud_q;
    tx_src_d = tx_src_q;
    tx_cnt_d = tx_cnt_q;
    rx_dst_d = rx_dst_q;
    rx_cnt_d = rx_cnt_q;
    eng_d = eng_q;
    {start_d, txe_d, rxf_d, txd_d, ferr_d, ovr_d} = {start_q, txe_q, rxf_q, txd_q, ferr_q, ovr_q};
    tx_buf_d = tx_buf_q;
    rx_buf_d = rx_buf_q;
    hold_d = hold_q;
    hold_full_d = hold_full_q;
    rx_hold_d = rx_hold_q;
    if (axi_req.awvalid && rsp_q.awready) begin
      aw_got_d = 1'b1;
      aw_addr_d = axi_req.awaddr;
    end
    if (axi_req.wvalid && rsp_q.wready) begin
      w_got_d = 1'b1;
      w_data_d = axi_req.wdata;
      w_strb_d = axi_req.wstrb;
    end
    if (rsp_q.bvalid && axi_req.bready) rsp_d.bvalid = 1'b0;
    // a write is done once address and data are both held
    if (aw_got_q && w_got_q && !rsp_q.bvalid) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      rsp_d.bvalid = 1'b1;
      rsp_d.bresp = is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      unique case (aw_addr_q)
        OFF_CTRL: begin
          wv = merge({26'h0, ctrl_q}, w_data_q, w_strb_q);
          ctrl_d = wv[5:0];
          // tx_on together with tx_empty_on in one write
          if (wv[C_TX_ON] && wv[C_TXE_ON] && !(ctrl_q[C_TX_ON] && ctrl_q[C_TXE_ON])) begin
            txe_d = 1'b1;
          end
        end
        OFF_STAT: begin
          wv = merge(32'h0000_0000, w_data_q, w_strb_q);
          start_d = start_q & ~wv[S_START];
          txe_d = txe_d & ~wv[S_TXE];
          rxf_d = rxf_q & ~wv[S_RXF];
          txd_d = txd_q & ~wv[S_TXD];
          ferr_d = ferr_q & ~wv[S_FERR];
          ovr_d = ovr_q & ~wv[S_OVR];
        end
        OFF_BAUD: baud_d = 8'(merge({24'h0, baud_q}, w_data_q, w_strb_q));
        OFF_TXSRC: tx_src_d = IW'(merge({{(32-IW){1'b0}}, tx_src_q}, w_data_q, w_strb_q));
        OFF_TXCNT: tx_cnt_d = 9'(merge({23'h0, tx_cnt_q}, w_data_q, w_strb_q));
        OFF_RXDST: rx_dst_d = IW'(merge({{(32-IW){1'b0}}, rx_dst_q}, w_data_q, w_strb_q));
        OFF_RXCNT: rx_cnt_d = 9'(merge({23'h0, rx_cnt_q}, w_data_q, w_strb_q));
        OFF_ENG: eng_d = 2'(merge({30'h0, eng_q}, w_data_q, w_strb_q));
        default: begin
          if (aw_addr_q[11:10] == WIN_TXBUF && w_strb_q[0]) begin
            tx_buf_d[IW'(aw_addr_q[9:2])] = w_data_q[7:0];
          end
        end
      endcase
      // dropping tx_on discards any byte waiting in the hold
      if (!ctrl_d[C_TX_ON]) begin
        hold_full_d = 1'b0;
        txd_d = 1'b0;
      end
    end
    // read channel: one outstanding, answered the cycle after ar
    if (rsp_q.rvalid && axi_req.rready) rsp_d.rvalid = 1'b0;
    if (axi_req.arvalid && rsp_q.arready) begin
      rsp_d.rvalid = 1'b1;
      rsp_d.rresp = is_mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      unique case (ra)
        OFF_CTRL: rsp_d.rdata = {26'h0, ctrl_q};
        OFF_STAT: rsp_d.rdata = {25'h0, hold_full_q, ovr_q, ferr_q, txd_q, rxf_q, txe_q, start_q};
        OFF_BAUD: rsp_d.rdata = {24'h0, baud_q};
        OFF_TXSRC: rsp_d.rdata = 32'(tx_src_q);
        OFF_TXCNT: rsp_d.rdata = {23'h0, tx_cnt_q};
        OFF_RXDST: rsp_d.rdata = 32'(rx_dst_q);
        OFF_RXCNT: rsp_d.rdata = {23'h0, rx_cnt_q};
        OFF_ENG: rsp_d.rdata = {30'h0, eng_q};
        default: begin
          rsp_d.rdata = '0;
          if (ra[11:10] == WIN_TXBUF) rsp_d.rdata = {24'h0, tx_buf_q[IW'(ra[9:2])]};
          if (ra[11:10] == WIN_RXBUF) rsp_d.rdata = {24'h0, rx_buf_q[IW'(ra[9:2])]};
        end
      endcase
    end
    rsp_d.awready = ~aw_got_d & ~rsp_d.bvalid;
    rsp_d.wready = ~w_got_d & ~rsp_d.bvalid;
    rsp_d.arready = ~rsp_d.rvalid;
    // engine moves: one byte per start, count runs down
    if (tx_go) begin
      txe_d = 1'b0;
      hold_d = tx_buf_q[tx_src_q];
      hold_full_d = 1'b1;
      txd_d = 1'b0;
      tx_src_d = tx_src_q + IW'(1);
      tx_cnt_d = tx_cnt_q - 9'h001;
    end
    if (rx_go) begin
      rxf_d = 1'b0;
      rx_buf_d[rx_dst_q] = rx_hold_q;
      rx_dst_d = rx_dst_q + IW'(1);
      rx_cnt_d = rx_cnt_q - 9'h001;
    end
    // hardware events last so they win over any clear
    if (sw_fall) start_d = 1'b1;
    if (tx_load) begin
      hold_full_d = 1'b0;
      txe_d = 1'b1;
    end
    if (tx_end) txd_d = 1'b1;
    if (rx_ok) begin
      if (rxf_q && !rx_go) begin
        ovr_d = 1'b1;
      end else begin
        rx_hold_d = rx_sh_q;
        rxf_d = 1'b1;
      end
    end
    if (rx_ferr) ferr_d = 1'b1;
    // the TXE and RXF requests reach the cpu once their descriptor is spent or off
    irq_d[I_TXE] = txe_d & ctrl_d[C_TXE_ON] & ((tx_cnt_d == '0) | ~eng_d[0]);
    irq_d[I_RXF] = rxf_d & ctrl_d[C_RXF_ON] & ((rx_cnt_d == '0) | ~eng_d[1]);
    irq_d[I_TXD] = txd_d & ctrl_d[C_TXD_ON];
    irq_d[I_FLT] = (ferr_d | ovr_d) & ctrl_d[C_FLT_ON];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rsp_q <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      ctrl_q <= CTRL_RST;
      baud_q <= BAUD_DIV_RST;
      tx_src_q <= '0;
      rx_dst_q <= '0;
      tx_cnt_q <= XFER_CNT_RST;
      rx_cnt_q <= XFER_CNT_RST;
      eng_q <= '0;
      {start_q, txe_q, rxf_q, txd_q, ferr_q, ovr_q} <= '0;
      hold_q <= '0;
      hold_full_q <= 1'b0;
      rx_hold_q <= '0;
      irq_q <= '0;
    end else begin
      rsp_q <= rsp_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      ctrl_q <= ctrl_d;
      baud_q <= baud_d;
      tx_src_q <= tx_src_d;
      rx_dst_q <= rx_dst_d;
      tx_cnt_q <= tx_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      eng_q <= eng_d;
      {start_q, txe_q, rxf_q, txd_q, ferr_q, ovr_q} <= {start_d, txe_d, rxf_d, txd_d, ferr_d, ovr_d};
      hold_q <= hold_d;
      hold_full_q <= hold_full_d;
      rx_hold_q <= rx_hold_d;
      irq_q <= irq_d;
    end
  end

  // buffers carry no reset: contents are software's business
  always_ff @(posedge clk_sys) begin
    tx_buf_q <= tx_buf_d;
    rx_buf_q <= rx_buf_d;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_hold_taken;
    hold_full_q && !txe_q;
  endsequence
  property p_tx_go;
    tx_go |=> s_hold_taken;
  endproperty
  a_tx_go: assert property (p_tx_go) else $error("tx start did not take byte");
  property p_load_sets;
    tx_load |=> txe_q && !hold_full_q && !tx_pin_q;
  endproperty
  a_load_sets: assert property (p_load_sets) else $error("shift load lost");
  property p_rx_hold;
    rx_ok && !rxf_q |=> rxf_q && rx_hold_q == $past(rx_sh_q);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx byte not held");
  property p_rx_go;
    rx_go && !rx_ok |=> !rxf_q && rx_cnt_q == $past(rx_cnt_q) - 9'h001;
  endproperty
  a_rx_go: assert property (p_rx_go) else $error("rx move wrong");
  property p_tx_spent;
    txe_q && ctrl_q[C_TXE_ON] && tx_cnt_q == '0 && !rst ##1 txe_q && ctrl_q[C_TXE_ON]
      |-> irq_q[I_TXE];
  endproperty
  a_tx_spent: assert property (p_tx_spent) else $error("spent tx not raised");
  property p_ferr;
    rx_ferr |=> ferr_q && $stable(rx_hold_q) && !$rose(rxf_q);
  endproperty
  a_ferr: assert property (p_ferr) else $error("fault byte mishandled");
  property p_start;
    sw_fall |=> start_q;
  endproperty
  a_start: assert property (p_start) else $error("start edge lost");
  property p_stop_high;
    tx_st_q == ST_STOP |-> tx_pin_q;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit low");
  property p_done;
    tx_end |=> txd_q ##1 (irq_q[I_TXD] == ctrl_q[C_TXD_ON]) || !txd_q;
  endproperty
  a_done: assert property (p_done) else $error("tx done missing");
endmodule : ubte_top

// *** ubte_pkg.sv ***
package ubte_pkg;
  // line timing: one bit lasts BAUD_MULT * (divisor + 1) clocks
  localparam int CLK_HZ = 50_000_000;
  localparam int LINE_BPS = 38400;
  localparam int BAUD_SHIFT = 5;
  localparam int BAUD_MULT = 1 << BAUD_SHIFT;
  localparam logic [7:0] BAUD_DIV_RST = 8'(CLK_HZ / (BAUD_MULT * LINE_BPS) - 1);
  localparam int BUF_BYTES = 256;
  localparam logic [8:0] XFER_CNT_RST = 9'h100;
  localparam int AW = 12;
  // register byte offsets
  localparam logic [AW-1:0] OFF_CTRL = 12'h000;
  localparam logic [AW-1:0] OFF_STAT = 12'h004;
  localparam logic [AW-1:0] OFF_BAUD = 12'h008;
  localparam logic [AW-1:0] OFF_TXSRC = 12'h00C;
  localparam logic [AW-1:0] OFF_TXCNT = 12'h010;
  localparam logic [AW-1:0] OFF_RXDST = 12'h014;
  localparam logic [AW-1:0] OFF_RXCNT = 12'h018;
  localparam logic [AW-1:0] OFF_ENG = 12'h01C;
  localparam logic [1:0] WIN_TXBUF = 2'h1;
  localparam logic [1:0] WIN_RXBUF = 2'h2;
  // serial_ctrl_word bits
  localparam int C_TX_ON = 0;
  localparam int C_RX_ON = 1;
  localparam int C_TXE_ON = 2;
  localparam int C_RXF_ON = 3;
  localparam int C_TXD_ON = 4;
  localparam int C_FLT_ON = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // status bits
  localparam int S_START = 0;
  localparam int S_TXE = 1;
  localparam int S_RXF = 2;
  localparam int S_TXD = 3;
  localparam int S_FERR = 4;
  localparam int S_OVR = 5;
  localparam int S_HOLD = 6;
  // request outputs
  localparam int I_TXE = 0;
  localparam int I_RXF = 1;
  localparam int I_TXD = 2;
  localparam int I_FLT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA = 4'b0100,
    ST_STOP = 4'b1000
  } ubte_ser_st_t;

  typedef struct packed {
    logic [AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } ubte_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } ubte_axi_rsp_t;
endpackage : ubte_pkg

// *** ubte_remote.sv ***
`timescale 1ns/100ps
// remote serial station on the far side of the line pins
module ubte_remote #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_sys, // bench clock
  input wire logic rst,     // sync reset, high
  input wire logic tx_pin,  // line driven by the port
  output logic rx_pin       // line driven by this station
);
  logic [7:0] got_q[$];
  logic [7:0] b;

  // the line idles high, as an unused uart line does
  initial rx_pin = 1'b1;

  // decode at mid-bit; a frame with a bad stop bit is not queued, so it shows as a lost byte
  always begin
    @(negedge tx_pin);
    if (!rst) begin
      repeat (BIT_CLKS / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge clk_sys);
        b[i] = tx_pin;
      end
      repeat (BIT_CLKS) @(posedge clk_sys);
      if (tx_pin === 1'b1) got_q.push_back(b);
    end
  end

  // one frame: start, 8 data lsb first, stop (low stop only to force a framing fault)
  task automatic send(input logic [7:0] d, input logic stop);
    rx_pin <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      rx_pin <= d[i];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    rx_pin <= stop;
    repeat (BIT_CLKS) @(posedge clk_sys);
    rx_pin <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk_sys);
  endtask : send
endmodule : ubte_remote

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import ubte_pkg::*;
  localparam int BIT_CLKS = BAUD_MULT;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic start_sw_pin = 1'b1;
  logic rx_pin;
  logic tx_pin;
  logic [3:0] irq_req;
  ubte_axi_req_t req = '{bready: 1'b1, rready: 1'b1, default: '0};
  ubte_axi_rsp_t rsp;
  int errors = 0;
  int comparisons = 0;
  int sent = 0;
  logic [31:0] seed = 32'hda3c;
  logic [31:0] rd;
  logic [7:0] tx_m[$];
  logic [7:0] rx_m[$];
  logic [5:0] ctrl;
  logic [2:0] seen;

  // 50 mhz system clock
  always #10 clk_sys = ~clk_sys;

  ubte_top dut (.clk_sys(clk_sys), .rst(rst), .axi_req(req), .axi_rsp(rsp),
    .start_sw_pin(start_sw_pin), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq_req(irq_req));
  ubte_remote #(.BIT_CLKS(BIT_CLKS)) remote (.clk_sys(clk_sys), .rst(rst), .tx_pin(tx_pin),
    .rx_pin(rx_pin));

  // xorshift source of payload bytes
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic end_sim();
    $display("counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo();
    errors++;
    $display("mismatch at %0t got %h exp %h (wait expired)", $time, irq_req, 4'hf);
    end_sim();
  endtask : tmo

  // bready and rready stay high, so a response is taken at the edge it is seen
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (!aw && !w && rsp.bvalid) begin
        chk({30'h0, rsp.bresp}, {30'h0, RESP_OKAY});
        return;
      end
      if (aw && rsp.awready) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    tmo();
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [1:0] er);
    logic ar;
    ar = 1'b1;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (!ar && rsp.rvalid) begin
        rd = rsp.rdata;
        chk({30'h0, rsp.rresp}, {30'h0, er});
        return;
      end
      if (ar && rsp.arready) begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
    end
    tmo();
  endtask : axi_rd

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    axi_rd(a, RESP_OKAY);
    chk(rd & m, exp);
  endtask : rdc

  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdc(OFF_CTRL, 32'h3f, {26'h0, CTRL_RST});
    rdc(OFF_BAUD, 32'hff, {24'h0, BAUD_DIV_RST});
    rdc(OFF_TXCNT, 32'h1ff, {23'h0, XFER_CNT_RST});
    axi_rd(12'h020, RESP_SLVERR);
    chk(rd, 32'h0);
    $display("test reset done");
    start_sw_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rdc(OFF_STAT, 32'h1, 32'h1);
    chk({28'h0, irq_req}, 32'h0);
    axi_wr(OFF_STAT, 32'h1);
    rdc(OFF_STAT, 32'h1, 32'h0);
    start_sw_pin <= 1'b1;
    axi_wr(OFF_CTRL, 32'h5);
    rdc(OFF_STAT, 32'h2, 32'h2);
    chk({31'h0, irq_req[I_TXE]}, 32'h1);
    axi_wr(OFF_CTRL, 32'h0);
    axi_wr(OFF_STAT, 32'h7f);
    $display("test start edge done");
    for (int i = 0; i < 4; i++) begin
      tx_m.push_back(8'(rnd()));
      axi_wr(12'h400 + 12'(4 * i), {24'h0, tx_m[i]});
    end
    axi_wr(OFF_BAUD, 32'h0);
    axi_wr(OFF_TXSRC, 32'h0);
    axi_wr(OFF_TXCNT, 32'h4);
    axi_wr(OFF_RXDST, 32'h0);
    axi_wr(OFF_RXCNT, 32'h3);
    axi_wr(OFF_ENG, 32'h3);
    ctrl = 6'h3f;
    axi_wr(OFF_CTRL, {26'h0, ctrl});
    fork
      for (int i = 0; i < 4; i++) begin
        rx_m.push_back(8'(rnd()));
        remote.send(rx_m[i], 1'b1);
        sent++;
      end
    join_none
    // handler: shut each direction down as its request reaches the cpu
    seen = 3'b000;
    for (int n = 0; n < 20000 && seen != 3'b111; n++) begin
      @(posedge clk_sys);
      if (!seen[0] && irq_req[I_TXE] === 1'b1) begin
        seen[0] = 1'b1;
        rdc(OFF_TXCNT, 32'h1ff, 32'h0);
        ctrl[C_TXE_ON] = 1'b0;
        axi_wr(OFF_CTRL, {26'h0, ctrl});
      end else if (!seen[1] && irq_req[I_RXF] === 1'b1) begin
        seen[1] = 1'b1;
        rdc(OFF_RXCNT, 32'h1ff, 32'h0);
        ctrl[C_RX_ON] = 1'b0;
        ctrl[C_RXF_ON] = 1'b0;
        axi_wr(OFF_CTRL, {26'h0, ctrl});
      end else if (!seen[2] && irq_req[I_TXD] === 1'b1) begin
        seen[2] = 1'b1;
        chk(32'(remote.got_q.size()), 32'h4);
        ctrl[C_TX_ON] = 1'b0;
        ctrl[C_TXD_ON] = 1'b0;
        axi_wr(OFF_CTRL, {26'h0, ctrl});
      end
    end
    if (seen != 3'b111) tmo();
    // the remote may still be finishing its last frame; bounded wait
    for (int n = 0; n < 2000 && sent < 4; n++) @(posedge clk_sys);
    if (sent < 4) tmo();
    for (int i = 0; i < 4; i++) chk({24'h0, remote.got_q[i]}, {24'h0, tx_m[i]});
    for (int i = 0; i < 3; i++) rdc(12'h800 + 12'(4 * i), 32'hff, {24'h0, rx_m[i]});
    rdc(OFF_TXSRC, 32'hff, 32'h4);
    rdc(OFF_RXDST, 32'hff, 32'h3);
    $display("test transfer done");
    axi_wr(OFF_STAT, 32'h7f);
    ctrl = 6'h22;
    axi_wr(OFF_CTRL, {26'h0, ctrl});
    remote.send(8'(rnd()), 1'b0);
    for (int n = 0; n < 400 && irq_req[I_FLT] !== 1'b1; n++) @(posedge clk_sys);
    chk({31'h0, irq_req[I_FLT]}, 32'h1);
    rdc(OFF_STAT, 32'h14, 32'h10);
    // rx_full stays pending with C_RXF_ON off and the rx count spent, so a second byte overruns
    remote.send(8'(rnd()), 1'b1);
    remote.send(8'(rnd()), 1'b1);
    rdc(OFF_STAT, 32'h24, 32'h24);
    $display("test framing done");
    end_sim();
  end
endmodule : tb_top
